// >>> verilog/cmr_map.vh
// register map constants for the cache management register unit
`ifndef CMR_MAP_VH
`define CMR_MAP_VH
`define CMR_GRP_DATA      5'h03
`define CMR_GRP_INSN      5'h04
`define CMR_IDX_DCTRL     11'h000
`define CMR_IDX_DPREF     11'h001
`define CMR_IDX_DFLUSH    11'h002
`define CMR_IDX_DINVAL    11'h003
`define CMR_IDX_DWBACK    11'h004
`define CMR_IDX_DLOCK     11'h005
`define CMR_IDX_ICTRL     11'h000
`define CMR_IDX_IPREF     11'h001
`define CMR_IDX_IINVAL    11'h002
`define CMR_IDX_ILOCK     11'h003
`define CMR_WAY_LSB       0
`define CMR_WAY_MSB       7
`define CMR_WAY_RESET     8'h00
`define CMR_EA_RESET      32'h00000000
`define CMR_OP_NONE       3'h0
`define CMR_OP_PREFETCH   3'h1
`define CMR_OP_FLUSH      3'h2
`define CMR_OP_INVALIDATE 3'h3
`define CMR_OP_WRITEBACK  3'h4
`define CMR_OP_LOCK       3'h5
`endif

// >>> verilog/cmr_cache_mgmt.v
// cache management special registers: way control and block operation dispatch
//
// Contract
// [R1] with no cache, writes to every register are dropped; core never stalls
// [R2] a unified cache drops writes to the instruction prefetch, invalidate and lock registers
// [R3] unified cache: both control register names reach one shared way register
// [R4] data registers in group 3 indices 0-5, instruction in group 4 indices 0-3
// [R5] user mode writes only prefetch, flush, write-back, instruction invalidate
// [R6] data control: way field bits 7-0 reset zero, upper bits read-only
// [R7] instruction control: way field bits 7-0 reset zero, upper bits read-only
// [R8] data control may be absent when no data way locking exists
// [R9] instruction control may be absent when no instruction way locking exists
// [R10] management traffic is not recorded as load/store and raises no exception
// [R11] software restores instruction coherence: write back, sync, invalidate, flush
// [R12] block registers are as wide as the implementation, 32 bits here
// [R13] optional data prefetch; when absent, writes are accepted and ignored
// [R14] data prefetch loads the block holding the address, as a hint only
// [R15] coherent flush invalidates everywhere, writing back a modified block first
// [R16] coherent flush missing locally makes peers write back and invalidate
// [R17] non-coherent flush acts locally; a local miss does nothing
// [R18] flush register is write-only, resets zero, any byte selects the block
// [R19] coherent supervisor invalidate kills the block everywhere without write-back
// [R20] coherent invalidate missing locally still invalidates peer copies
// [R21] non-coherent invalidate drops the local block, dirty or not; miss does nothing
// [R22] coherence requirement follows the page attribute bit, 1 meaning coherent
// [R23] each way field bit enables replacement into one cache way
`timescale 1ns/1ps
`include "cmr_map.vh"

module cmr_cache_mgmt
#(
    parameter HAS_DCACHE   = 1,
    parameter HAS_ICACHE   = 1,
    parameter UNIFIED      = 0,
    parameter HAS_DWAYLOCK = 1,
    parameter HAS_IWAYLOCK = 1,
    parameter HAS_DPREF    = 1
)
(
    input  wire        clk,
    input  wire        arst_n,
    // special register port from the core
    input  wire        spr_we,
    input  wire        spr_re,
    input  wire [4:0]  spr_group,
    input  wire [10:0] spr_index,
    input  wire [31:0] spr_wdata,
    input  wire        supervisor,
    input  wire        coherent_page_attribute,
    output reg  [31:0] spr_rdata,
    // data cache side
    output reg  [7:0]  data_way_enable,
    output reg         dcache_op_valid,
    output reg  [2:0]  dcache_op,
    output reg  [31:0] dcache_op_addr,
    output reg         dcache_op_coherent,
    // instruction cache side
    output reg  [7:0]  insn_way_enable,
    output reg         icache_op_valid,
    output reg  [2:0]  icache_op,
    output reg  [31:0] icache_op_addr,
    output reg         icache_op_coherent,
    // last flush address, kept for observation
    output reg  [31:0] data_block_flush
);

    // one-hot state of the command accepted in the previous cycle, idle otherwise (for visibility only)
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_DOP  = 3'b010;
    localparam [2:0] ST_IOP  = 3'b100;

    reg  [2:0] state;
    reg  [2:0] next_state;
    reg  [7:0] data_cache_control;
    reg  [7:0] instruction_cache_control;

    function hit;
        input [4:0]  grp;
        input [10:0] idx;
        input [4:0]  want_grp;
        input [10:0] want_idx;
        begin
            hit = (grp == want_grp) && (idx == want_idx);
        end
    endfunction

    // group of each managed register, in select vector order [R4]
    function [4:0] reg_grp;
        input integer n;
        begin
            if (n < 6)
                reg_grp = `CMR_GRP_DATA;
            else
                reg_grp = `CMR_GRP_INSN;
        end
    endfunction

    // index of each managed register inside its group [R4]
    function [10:0] reg_idx;
        input integer n;
        begin
            case (n)
                0: reg_idx = `CMR_IDX_DCTRL;
                1: reg_idx = `CMR_IDX_DPREF;
                2: reg_idx = `CMR_IDX_DFLUSH;
                3: reg_idx = `CMR_IDX_DINVAL;
                4: reg_idx = `CMR_IDX_DWBACK;
                5: reg_idx = `CMR_IDX_DLOCK;
                6: reg_idx = `CMR_IDX_ICTRL;
                7: reg_idx = `CMR_IDX_IPREF;
                8: reg_idx = `CMR_IDX_IINVAL;
                default: reg_idx = `CMR_IDX_ILOCK;
            endcase
        end
    endfunction

    // one comparator per managed register [R4]
    wire [9:0] sel;
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1)
        begin : g_sel
            assign sel[g] = hit(spr_group, spr_index, reg_grp(g), reg_idx(g));
        end
    endgenerate

    // group decode [R4]
    wire sel_dctrl  = sel[0];
    wire sel_dpref  = sel[1];
    wire sel_dflush = sel[2];
    wire sel_dinval = sel[3];
    wire sel_dwback = sel[4];
    wire sel_dlock  = sel[5];
    wire sel_ictrl  = sel[6];
    wire sel_ipref  = sel[7];
    wire sel_iinval = sel[8];
    wire sel_ilock  = sel[9];

    // cache presence gates; no write ever stalls the core [R1] [R2]
    wire d_on = (HAS_DCACHE != 0);
    wire i_on = (HAS_ICACHE != 0) && (UNIFIED == 0);

    // privilege check: silently dropped, never an exception [R5] [R10]
    wire wr_d = spr_we && d_on;
    wire wr_i = spr_we && i_on;
    wire w_dctrl  = wr_d && sel_dctrl && supervisor && (HAS_DWAYLOCK != 0); // [R5] [R8]
    wire w_ictrl_raw = spr_we && sel_ictrl && supervisor;
    // unified cache: instruction control name reaches the shared register [R3]
    wire w_ictrl_shared = w_ictrl_raw && d_on && (UNIFIED != 0) && (HAS_DWAYLOCK != 0);
    wire w_ictrl  = w_ictrl_raw && i_on && (HAS_IWAYLOCK != 0);                 // [R9]
    wire w_dpref  = wr_d && sel_dpref && (HAS_DPREF != 0);                      // [R13]
    wire w_dflush = wr_d && sel_dflush;                                        // [R5]
    wire w_dinval = wr_d && sel_dinval && supervisor;                          // [R5]
    wire w_dwback = wr_d && sel_dwback;
    wire w_dlock  = wr_d && sel_dlock && supervisor;                           // [R5]
    wire w_ipref  = wr_i && sel_ipref;
    wire w_iinval = wr_i && sel_iinval;                                        // [R5]
    wire w_ilock  = wr_i && sel_ilock && supervisor;                           // [R5]

    wire d_any = w_dpref | w_dflush | w_dinval | w_dwback | w_dlock;
    wire i_any = w_ipref | w_iinval | w_ilock;

    reg [2:0] next_dop;
    reg [2:0] next_iop;

    always @*
    begin
        next_dop = `CMR_OP_NONE;
        if (w_dpref)
            next_dop = `CMR_OP_PREFETCH;   // hint fill of the block [R14]
        else if (w_dflush)
            next_dop = `CMR_OP_FLUSH;      // dirty lines written back then dropped [R15] [R17]
        else if (w_dinval)
            next_dop = `CMR_OP_INVALIDATE; // dirty data discarded [R19] [R21]
        else if (w_dwback)
            next_dop = `CMR_OP_WRITEBACK;
        else if (w_dlock)
            next_dop = `CMR_OP_LOCK;
    end

    always @*
    begin
        next_iop = `CMR_OP_NONE;
        if (w_ipref)
            next_iop = `CMR_OP_PREFETCH;
        else if (w_iinval)
            next_iop = `CMR_OP_INVALIDATE;
        else if (w_ilock)
            next_iop = `CMR_OP_LOCK;
    end

    always @*
    begin
        case (state)
            ST_IDLE,
            ST_DOP,
            ST_IOP:
            begin
                if (d_any)
                    next_state = ST_DOP;
                else if (i_any)
                    next_state = ST_IOP;
                else
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    reg  [7:0] next_data_cache_control;
    reg  [7:0] next_instruction_cache_control;
    reg [31:0] next_rdata;

    // way field next values; reserved upper write bits are ignored [R6] [R7]
    always @*
    begin
        next_data_cache_control = data_cache_control;
        if (w_dctrl || w_ictrl_shared)
            next_data_cache_control = spr_wdata[`CMR_WAY_MSB:`CMR_WAY_LSB]; // [R6] [R3]
    end

    always @*
    begin
        next_instruction_cache_control = instruction_cache_control;
        if (w_ictrl)
            next_instruction_cache_control = spr_wdata[`CMR_WAY_MSB:`CMR_WAY_LSB]; // [R7]
    end

    // control reads are supervisor only; an absent register reads zero [R5] [R8] [R9]
    wire rd_dctrl = spr_re && supervisor && sel_dctrl && d_on && (HAS_DWAYLOCK != 0);
    wire rd_uctrl = spr_re && supervisor && sel_ictrl && d_on && (UNIFIED != 0)
                    && (HAS_DWAYLOCK != 0);
    wire rd_ictrl = spr_re && supervisor && sel_ictrl && i_on && (HAS_IWAYLOCK != 0);

    // reserved bits read as zero; the block registers are write-only [R18]
    always @*
    begin
        next_rdata = `CMR_EA_RESET;
        if (rd_dctrl)
            next_rdata = {24'h000000, data_cache_control};        // [R6]
        else if (rd_uctrl)
            next_rdata = {24'h000000, data_cache_control};        // [R3]
        else if (rd_ictrl)
            next_rdata = {24'h000000, instruction_cache_control}; // [R7]
    end

    // peers are reached on a local miss too; locks stay local [R16] [R20] [R22]
    wire next_dcoh = coherent_page_attribute && !w_dlock;
    wire next_icoh = coherent_page_attribute && !w_ilock; // [R22]

    // control registers and the visibility state [R6] [R7] [R23]
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_cache_control        <= `CMR_WAY_RESET;
            instruction_cache_control <= `CMR_WAY_RESET;
            state                     <= ST_IDLE;
        end
        else
        begin
            data_cache_control        <= next_data_cache_control;
            instruction_cache_control <= next_instruction_cache_control;
            state                     <= next_state;
        end
    end

    // data block strobe: one cycle, address of full width [R12]
    // the cache controller aligns the address to its block size [R18]
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dcache_op_valid    <= 1'b0;
            dcache_op          <= `CMR_OP_NONE;
            dcache_op_addr     <= `CMR_EA_RESET;
            dcache_op_coherent <= 1'b0;
        end
        else
        begin
            dcache_op_valid <= d_any;
            if (d_any)
            begin
                dcache_op          <= next_dop;
                dcache_op_addr     <= spr_wdata;
                dcache_op_coherent <= next_dcoh; // [R16] [R20]
            end
        end
    end

    // instruction block strobe: op, address and coherency hold until the next op
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            icache_op_valid    <= 1'b0;
            icache_op          <= `CMR_OP_NONE;
            icache_op_addr     <= `CMR_EA_RESET;
            icache_op_coherent <= 1'b0;
        end
        else
        begin
            icache_op_valid <= i_any;
            if (i_any)
            begin
                icache_op          <= next_iop;
                icache_op_addr     <= spr_wdata;
                icache_op_coherent <= next_icoh; // [R22]
            end
        end
    end

    // last flush address, reset to zero and never read back [R18]
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            data_block_flush <= `CMR_EA_RESET;
        else if (w_dflush)
            data_block_flush <= spr_wdata; // [R18]
    end

    // way enables trail the control registers by one cycle [R23]
    // unified: both enables follow the one shared register [R3]
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_way_enable <= `CMR_WAY_RESET;
            insn_way_enable <= `CMR_WAY_RESET;
        end
        else
        begin
            data_way_enable <= data_cache_control; // [R23]
            if (UNIFIED != 0)
                insn_way_enable <= data_cache_control;        // [R3]
            else
                insn_way_enable <= instruction_cache_control; // [R23]
        end
    end

    // read data stands for one cycle after the read strobe
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            spr_rdata <= `CMR_EA_RESET;
        else
            spr_rdata <= next_rdata;
    end

endmodule // cmr_cache_mgmt

// >>> dv/cmr_props.sv
// concurrent checks on the cache management register unit ports
`timescale 1ns/1ps
`include "cmr_map.vh"
module cmr_props
#(
    parameter HAS_DCACHE = 1,
    parameter HAS_ICACHE = 1,
    parameter UNIFIED    = 0
)
(
    input wire        clk,
    input wire        arst_n,
    input wire        spr_we,
    input wire [4:0]  spr_group,
    input wire [10:0] spr_index,
    input wire [31:0] spr_wdata,
    input wire        supervisor,
    input wire        coherent_page_attribute,
    input wire [7:0]  data_way_enable,
    input wire        dcache_op_valid,
    input wire [2:0]  dcache_op,
    input wire [31:0] dcache_op_addr,
    input wire        dcache_op_coherent,
    input wire        icache_op_valid,
    input wire [2:0]  icache_op,
    input wire [31:0] icache_op_addr,
    input wire [31:0] data_block_flush
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire wr3 = spr_we && spr_group == `CMR_GRP_DATA && HAS_DCACHE != 0;
    a_flush_issue: assert property (wr3 && spr_index == `CMR_IDX_DFLUSH |=>
        dcache_op_valid && dcache_op == `CMR_OP_FLUSH && dcache_op_addr == $past(spr_wdata))
        else $error("flush not issued");
    a_flush_keep: assert property (wr3 && spr_index == `CMR_IDX_DFLUSH |=>
        data_block_flush == $past(spr_wdata)) else $error("flush address not kept");
    a_user_drop: assert property (wr3 && !supervisor && (spr_index == `CMR_IDX_DINVAL
        || spr_index == `CMR_IDX_DLOCK) |=> !dcache_op_valid) else $error("user op taken");
    a_coh_follow: assert property (dcache_op_valid && dcache_op != `CMR_OP_LOCK |->
        dcache_op_coherent == $past(coherent_page_attribute)) else $error("coherency wrong");
    a_op_cause: assert property (dcache_op_valid |-> $past(spr_we)
        && $past(spr_group) == `CMR_GRP_DATA) else $error("data op without write");
    a_icache_cause: assert property (icache_op_valid |-> $past(spr_we)
        && $past(spr_group) == `CMR_GRP_INSN) else $error("insn op without write");
    a_way_lag: assert property (wr3 && supervisor && spr_index == `CMR_IDX_DCTRL |=>
        ##1 {24'h0, data_way_enable} == ($past(spr_wdata, 2) & 32'h000000ff))
        else $error("way enable wrong");
    a_insn_inval: assert property (UNIFIED == 0 && HAS_ICACHE != 0 &&
        spr_we && spr_group == `CMR_GRP_INSN &&
        spr_index == `CMR_IDX_IINVAL |=> icache_op_valid && icache_op == `CMR_OP_INVALIDATE
        && icache_op_addr == $past(spr_wdata)) else $error("insn invalidate lost");
    a_prefetch: assert property (wr3 && spr_index == `CMR_IDX_DPREF |=>
        dcache_op_valid && dcache_op == `CMR_OP_PREFETCH) else $error("prefetch lost");
endmodule // cmr_props
bind cmr_cache_mgmt cmr_props #(.HAS_DCACHE(HAS_DCACHE), .HAS_ICACHE(HAS_ICACHE),
    .UNIFIED(UNIFIED)) u_props (.clk(clk), .arst_n(arst_n), .spr_we(spr_we),
    .spr_group(spr_group), .spr_index(spr_index), .spr_wdata(spr_wdata),
    .supervisor(supervisor), .coherent_page_attribute(coherent_page_attribute),
    .data_way_enable(data_way_enable), .dcache_op_valid(dcache_op_valid),
    .dcache_op(dcache_op), .dcache_op_addr(dcache_op_addr),
    .dcache_op_coherent(dcache_op_coherent), .icache_op_valid(icache_op_valid),
    .icache_op(icache_op), .icache_op_addr(icache_op_addr),
    .data_block_flush(data_block_flush));

// >>> dv/cmr_core_model.sv
// core-side model that issues special register moves, one per call
`timescale 1ns/1ps
module cmr_core_model
(
    output logic        we,
    output logic        re,
    output logic [4:0]  grp,
    output logic [10:0] idx,
    output logic [31:0] wdata,
    output logic        sup,
    output logic        coh
);
    initial {we, re, grp, idx, wdata, sup, coh} = '0;
    // called just after a falling edge; a move stands until the next call
    task put(input logic w, r, input logic [4:0] g, input logic [10:0] x,
             input logic [31:0] d, input logic s, c);
        {we, re, grp, idx, wdata, sup, coh} = {w, r, g, x, d, s, c};
    endtask
endmodule // cmr_core_model

// >>> dv/cache_management_registers_bench.sv
// random and corner special register traffic with self-checking
`timescale 1ns/1ps
module cache_management_registers_bench;
    logic clk = 0, arst_n = 0;
    logic we, re, sup, coh;
    logic [4:0] grp;
    logic [10:0] idx;
    logic [31:0] wd, rdata, dadr, iadr, flush, r, pa, prd, urd, nrd, nflush, purd;
    logic [7:0] dway, iway, mdway, miway, udway, uiway, nway, mu;
    logic dval, dcoh, ival, icoh, pre, pc, udval, uival, nval, nival, w;
    logic [2:0] dop, iop;
    logic [3:0] pv;
    logic [4:0] pg;
    logic [10:0] px;
    integer seed = 32'h18a3540a, fails = 0, num_checks = 0, i;
    cmr_core_model core (.we(we), .re(re), .grp(grp), .idx(idx), .wdata(wd), .sup(sup), .coh(coh));
    cmr_cache_mgmt dut (.clk(clk), .arst_n(arst_n), .spr_we(we), .spr_re(re), .spr_group(grp),
        .spr_index(idx), .spr_wdata(wd), .supervisor(sup), .coherent_page_attribute(coh),
        .spr_rdata(rdata), .data_way_enable(dway), .dcache_op_valid(dval), .dcache_op(dop),
        .dcache_op_addr(dadr), .dcache_op_coherent(dcoh), .insn_way_enable(iway),
        .icache_op_valid(ival), .icache_op(iop), .icache_op_addr(iadr),
        .icache_op_coherent(icoh), .data_block_flush(flush));
    cmr_cache_mgmt #(.UNIFIED(1)) dut_uni (.clk(clk), .arst_n(arst_n), .spr_we(we),
        .spr_re(re), .spr_group(grp), .spr_index(idx), .spr_wdata(wd), .supervisor(sup),
        .coherent_page_attribute(coh), .spr_rdata(urd), .data_way_enable(udway),
        .dcache_op_valid(udval), .dcache_op(), .dcache_op_addr(), .dcache_op_coherent(),
        .insn_way_enable(uiway), .icache_op_valid(uival), .icache_op(), .icache_op_addr(),
        .icache_op_coherent(), .data_block_flush());
    cmr_cache_mgmt #(.HAS_DCACHE(0), .HAS_ICACHE(0)) dut_none (.clk(clk), .arst_n(arst_n),
        .spr_we(we), .spr_re(re), .spr_group(grp), .spr_index(idx), .spr_wdata(wd),
        .supervisor(sup), .coherent_page_attribute(coh), .spr_rdata(nrd),
        .data_way_enable(nway), .dcache_op_valid(nval), .dcache_op(), .dcache_op_addr(),
        .dcache_op_coherent(), .insn_way_enable(), .icache_op_valid(nival), .icache_op(),
        .icache_op_addr(), .icache_op_coherent(), .data_block_flush(nflush));
    initial forever #5 clk = ~clk;
    // {valid, op}; privileged registers drop user writes
    function automatic [3:0] exp_op(input [4:0] g, input [10:0] x, input s);
        if (g == 3 && x >= 1 && x <= 5)
            exp_op = (x == 3 || x == 5) && !s ? 4'h0 : {1'b1, x[2:0]};
        else if (g == 4 && x >= 1 && x <= 3)
            exp_op = x == 3 && !s ? 4'h0 : {1'b1, x == 1 ? 3'h1 : (x == 2 ? 3'h3 : 3'h5)};
        else
            exp_op = 4'h0;
    endfunction
    task chk(input logic [79:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #50000 fails++;
        test_done;
    end
    initial
    begin
        {mdway, miway, mu, pg, pv, pre} = '0;
        repeat (2) @(negedge clk);
        chk({dval, ival, dway, iway, flush}, 0);
        arst_n = 1;
        for (i = 0; i < 300; i++)
        begin
            @(negedge clk);
            chk({dval, ival}, {pg == 3 && pv[3], pg == 4 && pv[3]});
            chk({udval, uival}, {pg == 3 && pv[3], 1'b0});
            chk({nval, nival, nrd, nflush, nway}, 0);
            if (pv[3] && pg == 3)
                chk({dcoh, dop, dadr}, {pc && pv[2:0] != 5, pv[2:0], pa});
            if (pv[3] && pg == 4)
                chk({icoh, iop, iadr}, {pc && pv[2:0] != 5, pv[2:0], pa});
            if (pv == 4'ha && pg == 3)
                chk(flush, pa);
            if (pre)
                chk(rdata, prd);
            if (pre)
                chk(urd, purd);
            r = $random(seed);
            w = r[5] || i < 3;
            pg = i < 3 ? (i == 1 ? 4 : 3) : 5'd3 + r[1:0] % 3;
            // write back, then invalidate the instruction block, then a user flush
            px = i < 3 ? (i == 0 ? 4 : 2) : r[4:2] % 6;
            pa = i == 2 ? 32'hffffffff : $random(seed);
            pre = !w && r[6] && r[7];
            pc = r[8];
            prd = px == 0 && r[7] ? {24'h0, pg == 3 ? mdway : (pg == 4 ? miway : 8'h0)} : 0;
            purd = px == 0 && r[7] && pg != 5 ? {24'h0, mu} : 0;
            if (pg == 3 && px == 0 && w && r[7])
                mdway = pa[7:0];
            if (pg == 4 && px == 0 && w && r[7])
                miway = pa[7:0];
            if (pg != 5 && px == 0 && w && r[7])
                mu = pa[7:0];
            core.put(w, pre, pg, px, pa, r[7] && i > 2, pc);
            pv = w ? exp_op(pg, px, r[7] && i > 2) : 4'h0;
        end
        core.put(0, 0, 0, 0, 0, 0, 0);
        repeat (3) @(negedge clk);
        chk({dway, iway}, {mdway, miway});
        chk({udway, uiway}, {mu, mu});
        test_done;
    end
endmodule // cache_management_registers_bench
